// ===== include/evt_flags_pkg.sv
// Purpose: Constants for the event flag and power-good block
// Assumes: 8-bit registers on a byte-addressed internal register port
// Notes: Offsets are byte addresses of the serial control port map
package evt_flags_pkg;
   localparam logic [7:0] REGGOOD2_OFS = 8'h38;
   localparam logic [7:0] STS1_OFS = 8'h39;
   localparam logic [7:0] MSK1_OFS = 8'h3A;
   localparam logic [7:0] STS2_OFS = 8'h3B;
   localparam logic [7:0] MSK2_OFS = 8'h3C;
   localparam logic [7:0] STS1_RST = 8'h00;
   localparam logic [7:0] STS2_RST = 8'h00;
   localparam logic [7:0] MSK_RST = 8'hFF;
   localparam logic [1:0] REGGOOD2_RSVD = 2'h0;
   // Field positions in the first status register
   localparam int PIN1_FALL_BIT = 7;
   localparam int PIN1_RISE_BIT = 6;
   localparam int OVERTEMP_BIT = 5;
   localparam int HOLD_RISE_BIT = 4;
   localparam int LONG_PRESS_BIT = 3;
   localparam int BUTTON_BIT = 2;
   localparam int MONITOR_LOW_BIT = 1;
   localparam int HOLD_FALL_BIT = 0;
   localparam int NUM_GOOD = 6;
   localparam int NUM_PINS2 = 4;
endpackage : evt_flags_pkg

// ===== verilog/evt_flags.sv
// Purpose: Sticky event flags, masks, interrupt request, power-good readback
// Assumes: Detector and comparator inputs are synchronous to clk_i
// Notes: Mask reset values come in from one-time-programmed defaults
// Function
// - Good bits 5..0 mirror regulators 10..5
// - Good bit meaningless while supply below 1V
// - Good register bits 7..6 read zero
// - Pin1 falling edge sets status bit 7
// - Pin1 rising edge sets status bit 6
// - Overtemp warning sets status bit 5
// - Hold pin rise bit 4, fall bit 0
// - Button long press sets bit 3
// - Button event sets bit 2
// - Monitor below threshold sets bit 1 immediately
// - Write one clears flag, zero keeps
// - First status resets to zero
// - Mask bit one masks same-position event
// - First mask resets to programmed defaults
// - Second status holds pin5..2 edge flags
// - Second status resets to zero
// - Second mask gates pin5..2 edges
`timescale 1ns/1ps
module evt_flags
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Programmed mask defaults, sampled after reset release
   input wire logic [7:0] mask1_otp_i,
   input wire logic [7:0] mask2_otp_i,
   // Register port
   input wire logic [7:0] addr_i,
   input wire logic wr_en_i,
   input wire logic [7:0] wr_data_i,
   output logic [7:0] rd_data_o,
   // Event sources
   input wire logic [5:1] pin_i,
   input wire logic overtemp_warn_i,
   input wire logic hold_pin_i,
   input wire logic button_pin_n_i,
   input wire logic button_long_press_i,
   input wire logic supply_monitor_below_i,
   // Regulator power-good comparators, bit 0 = regulator 5
   input wire logic [5:0] reg_good_i,
   input wire logic [5:0] reg_supply_low_i,
   // Outputs
   output logic [1:0] supply_monitor_threshold_sel_o,
   output logic [5:0] reg_good_valid_o,
   output logic irq_o
);
   logic [7:0] sts1_reg;
   logic [7:0] sts2_reg;
   logic [7:0] msk1_reg;
   logic [7:0] msk2_reg;
   logic [5:0] good_reg;
   logic [5:1] pin_q;
   logic hold_q;
   logic button_n_q;
   logic monitor_q;
   logic otp_loaded;
   logic [7:0] set1;
   logic [7:0] set2;
   logic wr_sts1;
   logic wr_sts2;
   logic [7:0] clr1;
   logic [7:0] clr2;
   logic [7:0] good_word;

   // ---------------------------------------------------------------
   // Edge detection
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         pin_q <= 5'h00;
         hold_q <= 1'b0;
         button_n_q <= 1'b1;
         monitor_q <= 1'b0;
      end
      else
      begin
         pin_q <= pin_i;
         hold_q <= hold_pin_i;
         button_n_q <= button_pin_n_i;
         monitor_q <= supply_monitor_below_i;
      end
   end

   always_comb
   begin
      set1 = 8'h00;
      // Pin and hold levels held through reset are no edges, so the first edge only primes
      set1[evt_flags_pkg::PIN1_FALL_BIT] = otp_loaded & pin_q[1] & ~pin_i[1];
      set1[evt_flags_pkg::PIN1_RISE_BIT] = otp_loaded & ~pin_q[1] & pin_i[1];
      set1[evt_flags_pkg::OVERTEMP_BIT] = overtemp_warn_i;
      set1[evt_flags_pkg::HOLD_RISE_BIT] = otp_loaded & ~hold_q & hold_pin_i;
      set1[evt_flags_pkg::HOLD_FALL_BIT] = otp_loaded & hold_q & ~hold_pin_i;
      set1[evt_flags_pkg::LONG_PRESS_BIT] = button_long_press_i;
      // Press is the falling edge of the active-low button
      set1[evt_flags_pkg::BUTTON_BIT] = button_n_q & ~button_pin_n_i;
      // Entering low supply sets at once, no filter
      set1[evt_flags_pkg::MONITOR_LOW_BIT] = ~monitor_q & supply_monitor_below_i;
   end

   // Pin n falling at bit 2n-3, rising at bit 2n-4
   always_comb
   begin
      set2 = 8'h00;
      for (int p = 0; p < evt_flags_pkg::NUM_PINS2; p++)
      begin
         set2[2*p+1] = otp_loaded & pin_q[p+2] & ~pin_i[p+2];
         set2[2*p] = otp_loaded & ~pin_q[p+2] & pin_i[p+2];
      end
   end

   AST_PIN1_FALL: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (otp_loaded && pin_q[1] && !pin_i[1]) |=> sts1_reg[7])
      else $error("pin1 fall not flagged");
   AST_PIN1_RISE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (otp_loaded && !pin_q[1] && pin_i[1]) |=> sts1_reg[6])
      else $error("pin1 rise not flagged");
   AST_HOLD_RISE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (otp_loaded && !hold_q && hold_pin_i) |=> sts1_reg[4])
      else $error("hold rise not flagged");
   AST_HOLD_FALL: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (otp_loaded && hold_q && !hold_pin_i) |=> sts1_reg[0])
      else $error("hold fall not flagged");
   AST_OVERTEMP: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      overtemp_warn_i |=> sts1_reg[5])
      else $error("overtemp not flagged");
   AST_LONG_PRESS: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      button_long_press_i |=> sts1_reg[3])
      else $error("long press not flagged");
   AST_BUTTON: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (button_n_q && !button_pin_n_i) |=> sts1_reg[2])
      else $error("button press not flagged");
   AST_MONITOR: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      $rose(supply_monitor_below_i) |=> sts1_reg[1])
      else $error("monitor low not flagged");
   AST_PIN5_RISE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (otp_loaded && !pin_q[5] && pin_i[5]) |=> sts2_reg[6])
      else $error("pin5 rise not flagged");
   AST_PIN2_FALL: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (otp_loaded && pin_q[2] && !pin_i[2]) |=> sts2_reg[1])
      else $error("pin2 fall not flagged");

   // ---------------------------------------------------------------
   // Status registers
   // ---------------------------------------------------------------
   assign wr_sts1 = wr_en_i && (addr_i == evt_flags_pkg::STS1_OFS);
   assign wr_sts2 = wr_en_i && (addr_i == evt_flags_pkg::STS2_OFS);
   assign clr1 = wr_sts1 ? wr_data_i : 8'h00;
   assign clr2 = wr_sts2 ? wr_data_i : 8'h00;

   // Set wins over a clear in the same cycle so no event is lost
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         sts1_reg <= evt_flags_pkg::STS1_RST;
      end
      else
      begin
         sts1_reg <= (sts1_reg & ~clr1) | set1;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         sts2_reg <= evt_flags_pkg::STS2_RST;
      end
      else
      begin
         sts2_reg <= (sts2_reg & ~clr2) | set2;
      end
   end

   AST_STICKY: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (sts1_reg[5] && !(wr_sts1 && wr_data_i[5])) |=> sts1_reg[5])
      else $error("flag lost without clear");
   AST_CLEAR: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (wr_sts1 && wr_data_i[2] && !set1[2]) |=> !sts1_reg[2])
      else $error("write one did not clear");
   AST_CLEAR2: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (wr_sts2 && wr_data_i[0] && !set2[0]) |=> !sts2_reg[0])
      else $error("second status write one did not clear");
   AST_SET_WINS: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (wr_sts1 && ((wr_data_i & set1) != 8'h00)) |=> ((sts1_reg & $past(set1)) == $past(set1)))
      else $error("event lost to clear");
   AST_PRIME: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      !otp_loaded |=> (sts2_reg == 8'h00))
      else $error("false edge after reset");

   // ---------------------------------------------------------------
   // Mask registers
   // ---------------------------------------------------------------
   // Defaults cannot be loaded under async reset, so take them once after
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         otp_loaded <= 1'b0;
         msk1_reg <= evt_flags_pkg::MSK_RST;
         msk2_reg <= evt_flags_pkg::MSK_RST;
      end
      else if (!otp_loaded)
      begin
         otp_loaded <= 1'b1;
         msk1_reg <= mask1_otp_i;
         msk2_reg <= mask2_otp_i;
      end
      else if (wr_en_i)
      begin
         if (addr_i == evt_flags_pkg::MSK1_OFS)
         begin
            msk1_reg <= wr_data_i;
         end
         if (addr_i == evt_flags_pkg::MSK2_OFS)
         begin
            msk2_reg <= wr_data_i;
         end
      end
   end

   AST_OTP_LOAD: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      !otp_loaded |=> (msk1_reg == $past(mask1_otp_i)))
      else $error("mask defaults not loaded");
   AST_MASK2_WRITE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (otp_loaded && wr_en_i && (addr_i == evt_flags_pkg::MSK2_OFS))
      |=> (msk2_reg == $past(wr_data_i)))
      else $error("second mask write lost");

   // ---------------------------------------------------------------
   // Power-good mirror and monitor threshold
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         good_reg <= 6'h00;
         reg_good_valid_o <= 6'h00;
      end
      else
      begin
         good_reg <= reg_good_i;
         // Flag bits whose value is meaningful for software
         reg_good_valid_o <= ~reg_supply_low_i;
      end
   end

   AST_GOOD_MIRROR: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      1'b1 |=> good_reg == $past(reg_good_i))
      else $error("good mirror wrong");
   AST_VALID: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      1'b1 |=> (reg_good_valid_o == ~$past(reg_supply_low_i)))
      else $error("good validity wrong");

   // Threshold select lives in a register outside this block's map
   assign supply_monitor_threshold_sel_o = 2'h0;

   // ---------------------------------------------------------------
   // Readback and interrupt
   // ---------------------------------------------------------------
   // Reserved upper bits are wired to zero, never stored
   assign good_word = {evt_flags_pkg::REGGOOD2_RSVD, good_reg};

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         rd_data_o <= 8'h00;
      end
      else
      begin
         case (addr_i)
            evt_flags_pkg::REGGOOD2_OFS: rd_data_o <= good_word;
            evt_flags_pkg::STS1_OFS: rd_data_o <= sts1_reg;
            evt_flags_pkg::MSK1_OFS: rd_data_o <= msk1_reg;
            evt_flags_pkg::STS2_OFS: rd_data_o <= sts2_reg;
            evt_flags_pkg::MSK2_OFS: rd_data_o <= msk2_reg;
            default: rd_data_o <= 8'h00;
         endcase
      end
   end

   assign irq_o = (|(sts1_reg & ~msk1_reg)) | (|(sts2_reg & ~msk2_reg));

   AST_RSVD_ZERO: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (addr_i == evt_flags_pkg::REGGOOD2_OFS) |=> rd_data_o[7:6] == 2'h0)
      else $error("reserved bits nonzero");
   AST_IRQ: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      ((sts2_reg & ~msk2_reg) != 8'h00) |-> irq_o)
      else $error("irq missing");
   AST_IRQ_ONE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      ((sts1_reg & ~msk1_reg) != 8'h00) |-> irq_o)
      else $error("irq missing for first status");
   AST_IRQ_QUIET: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (((sts1_reg & ~msk1_reg) | (sts2_reg & ~msk2_reg)) == 8'h00) |-> !irq_o)
      else $error("irq without unmasked flag");
endmodule : evt_flags

// ===== tb/host_model.sv
// Purpose: Host model driving the device register port
// Assumes: Read data registered one cycle after the address
// Notes: Signals move 1 ns after a rising edge only
`timescale 1ns/1ps
module host_model
(
   // Clock
   input wire logic clk_i,
   // Register port
   output logic [7:0] addr_o,
   output logic wr_en_o,
   output logic [7:0] wr_data_o,
   input wire logic [7:0] rd_data_i
);
   initial
   begin
      addr_o = 8'h00;
      wr_en_o = 1'h0;
      wr_data_o = 8'h00;
   end
   // Idle edge after each write keeps back-to-back strobes apart
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      addr_o = a;
      wr_data_o = d;
      wr_en_o = 1'h1;
      @(posedge clk_i);
      #1;
      wr_en_o = 1'h0;
      @(posedge clk_i);
      #1;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      addr_o = a;
      @(posedge clk_i);
      #1;
      d = rd_data_i;
   endtask : rd
endmodule : host_model

// ===== tb/evt_flags_tb.sv
// Purpose: Self-checking bench for the event flag block
// Assumes: Caller tasks start 1 ns after a rising edge
// Notes: Seeded random masks, defaults and comparator levels
`timescale 1ns/1ps
module evt_flags_tb;
   logic clk_i, rst_b_i, wr_en, ovt, hold, btn_n, lp, mon, irq;
   logic [7:0] otp1, otp2, addr, wdata, rdata, m, r;
   logic [5:1] pins;
   logic [5:0] good, low, gvalid;
   logic [1:0] thr;
   int bad_count, checks;
   int order[8] = '{6, 7, 5, 4, 0, 3, 2, 1};
   evt_flags DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .mask1_otp_i(otp1),
      .mask2_otp_i(otp2), .addr_i(addr), .wr_en_i(wr_en), .wr_data_i(wdata),
      .rd_data_o(rdata), .pin_i(pins), .overtemp_warn_i(ovt), .hold_pin_i(hold),
      .button_pin_n_i(btn_n), .button_long_press_i(lp), .supply_monitor_below_i(mon),
      .reg_good_i(good), .reg_supply_low_i(low), .supply_monitor_threshold_sel_o(thr),
      .reg_good_valid_o(gvalid), .irq_o(irq));
   host_model host (.clk_i(clk_i), .addr_o(addr), .wr_en_o(wr_en), .wr_data_o(wdata),
      .rd_data_i(rdata));
   task automatic complete_run();
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : complete_run
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      checks++;
      if (g !== e)
      begin
         bad_count++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask : chk
   task automatic chk_irq(input logic g, input logic e);
      checks++;
      if (g !== e)
      begin
         bad_count++;
         $display("unexpected at %0t: irq %b want %b", $time, g, e);
      end
   endtask : chk_irq
   function automatic logic [7:0] onehot(input int k);
      onehot = 8'h00;
      onehot[k] = 1'h1;
   endfunction : onehot
   task automatic tick();
      @(posedge clk_i);
      #1;
   endtask : tick
   // --------------------------------
   // Event stimulus, pulses last one edge
   // --------------------------------
   task automatic fire(input int k);
      case (k)
         6: pins[1] = 1'h1;
         7: pins[1] = 1'h0;
         5: ovt = 1'h1;
         4: hold = 1'h1;
         0: hold = 1'h0;
         3: lp = 1'h1;
         2: btn_n = 1'h0;
         default: mon = 1'h1;
      endcase
      tick();
      ovt = 1'h0;
      lp = 1'h0;
      btn_n = 1'h1;
      mon = 1'h0;
      tick();
   endtask : fire
   initial
   begin
      clk_i = 1'h0;
      forever #2 clk_i = ~clk_i;
   end
   initial
   begin
      #20000;
      bad_count++;
      complete_run();
   end
   initial
   begin
      void'($urandom(76));
      otp1 = 8'($urandom);
      otp2 = 8'($urandom);
      {rst_b_i, pins, ovt, hold, lp, mon, good, low} = '0;
      btn_n = 1'h1;
      repeat (4) @(posedge clk_i);
      #1 rst_b_i = 1'h1;
      tick();
      tick();
      host.rd(8'h39, r);
      chk(r, 8'h00);
      host.rd(8'h3B, r);
      chk(r, 8'h00);
      host.rd(8'h3A, r);
      chk(r, otp1);
      host.rd(8'h3C, r);
      chk(r, otp2);
      chk_irq(irq, 1'h0);
      chk({6'h00, thr}, 8'h00);
      for (int i = 0; i < 8; i++)
      begin
         m = 8'($urandom);
         host.wr(8'h3A, m);
         fire(order[i]);
         host.rd(8'h39, r);
         chk(r, onehot(order[i]));
         chk_irq(irq, ~m[order[i]]);
         host.wr(8'h39, 8'h00);
         host.rd(8'h39, r);
         chk(r, onehot(order[i]));
         host.wr(8'h39, onehot(order[i]));
         host.rd(8'h39, r);
         chk(r, 8'h00);
      end
      host.wr(8'h3C, 8'h00);
      for (int n = 2; n < 6; n++)
      begin
         pins[n] = 1'h1;
         tick();
         tick();
         host.rd(8'h3B, r);
         chk(r, onehot(2 * n - 4));
         pins[n] = 1'h0;
         tick();
         tick();
         host.rd(8'h3B, r);
         chk(r, onehot(2 * n - 4) | onehot(2 * n - 3));
         chk_irq(irq, 1'h1);
         host.wr(8'h3C, 8'hFF);
         chk_irq(irq, 1'h0);
         host.wr(8'h3C, 8'h00);
         host.wr(8'h3B, 8'hFF);
         host.rd(8'h3B, r);
         chk(r, 8'h00);
      end
      // Mid-run reset with pin 2 held high must not flag an edge
      pins[2] = 1'h1;
      tick();
      rst_b_i = 1'h0;
      tick();
      rst_b_i = 1'h1;
      tick();
      tick();
      host.rd(8'h3B, r);
      chk(r, 8'h00);
      host.rd(8'h3A, r);
      chk(r, otp1);
      pins[2] = 1'h0;
      tick();
      tick();
      host.rd(8'h3B, r);
      chk(r, onehot(1));
      for (int j = 0; j < 24; j++)
      begin
         good = 6'($urandom);
         low = 6'($urandom);
         tick();
         host.rd(8'h38, r);
         chk(r, {2'h0, good});
         chk({2'h0, gvalid}, {2'h0, ~low});
      end
      complete_run();
   end
endmodule : evt_flags_tb
